// *** rtl/alarm_shift_if.sv ***
`timescale 1ns/1ns
`default_nettype none

// Controller to serializer: word load and overhead slot timing
interface alarm_shift_if;
   logic        load;
   logic [15:0] word;
   logic        slot;
   logic        cur_bit;
   logic        done;

   modport ctrl (output load, output word, output slot, input cur_bit, input done);
   modport ser  (input load, input word, input slot, output cur_bit, output done);
endinterface : alarm_shift_if

`default_nettype wire

// *** rtl/alarm_tx_pkg.sv ***
package alarm_tx_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [13:0] IDX_TX_CONTROL        = 14'h00C0;
   localparam logic [13:0] IDX_TX_CODES          = 14'h00C2;
   localparam logic [13:0] IDX_TX_STATUS         = 14'h00C4;
   localparam logic [13:0] IDX_TX_STATUS_LATCHED = 14'h00C6;
   localparam logic [13:0] IDX_TX_IRQ_ENABLE     = 14'h00C8;
   localparam logic [13:0] IDX_PORT_STRIDE       = 14'h0200;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          CTRL_MODE_LSB      = 0;
   localparam int          CTRL_LOAD_BIT      = 2;
   localparam int          CODE_A_LSB         = 0;
   localparam int          CODE_B_LSB         = 8;
   localparam int          CODE_WIDTH         = 6;
   localparam int          IDLE_BIT           = 0;
   localparam logic [15:0] RST_TX_CONTROL     = 16'h0800;
   localparam logic [15:0] RST_TX_CODES       = 16'h0000;
   localparam logic [15:0] RST_TX_IRQ_ENABLE  = 16'h0000;
   localparam logic [15:0] MASK_TX_CODES      = 16'h3F3F;
   localparam logic [15:0] MASK_TX_IRQ_ENABLE = 16'h0001;

   // ------------------------------------------------------------
   // Codeword shape and repetition
   // ------------------------------------------------------------
   localparam int         CODEWORD_BITS      = 16;
   localparam logic [7:0] CODEWORD_TAIL      = 8'hFF;
   localparam int         ALARM_REPEAT_COUNT = 10;

   typedef enum logic [1:0]
   {
      MODE_IDLE   = 2'h0,
      MODE_SINGLE = 2'h1,
      MODE_DUAL   = 2'h2,
      MODE_CONT   = 2'h3
   } codeword_mode_t;

   typedef enum logic [3:0]
   {
      ST_IDLE   = 4'h1,
      ST_SEND_A = 4'h2,
      ST_SEND_B = 4'h4,
      ST_CONT   = 4'h8
   } sender_state_t;

   // Zero, six code bits first bit first, zero, eight ones
   function automatic logic [15:0] build_codeword(input logic [5:0] code);
      build_codeword = {1'b0, code[0], code[1], code[2], code[3], code[4], code[5],
                        1'b0, CODEWORD_TAIL};
   endfunction : build_codeword

endpackage : alarm_tx_pkg

// *** rtl/codeword_serializer.sv ***
`timescale 1ns/1ns
`default_nettype none

module codeword_serializer
   import alarm_tx_pkg::*;
(
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   alarm_shift_if.ser    sh
);

   logic [15:0] word_ff;
   logic [3:0]  cnt_ff;

   // ------------------------------------------------------------
   // Shift decode
   // ------------------------------------------------------------
   // Done ignores load so no loop forms; the controller masks it on a reload
   assign sh.cur_bit = word_ff[CODEWORD_BITS-1];
   assign sh.done    = sh.slot & (cnt_ff == 4'(CODEWORD_BITS - 1));

   // Ones fill in behind the word, so a stalled shifter still idles
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         word_ff <= 16'hFFFF;
         cnt_ff  <= 4'h0;
      end
      else if (sh.load)
      begin
         word_ff <= sh.word;
         cnt_ff  <= 4'h0;
      end
      else if (sh.slot)
      begin
         word_ff <= {word_ff[14:0], 1'b1};
         cnt_ff  <= cnt_ff + 4'h1;
      end
   end

endmodule : codeword_serializer

`default_nettype wire

// *** rtl/far_end_alarm_code_transmitter.sv ***
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module far_end_alarm_code_transmitter
   import alarm_tx_pkg::*;
#(
   parameter int PORT_NUM     = 0,
   parameter int REPEAT_COUNT = ALARM_REPEAT_COUNT
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        overhead_slot_i,
   input  wire logic [3:0]  port_status_irq_enable_i,
   output logic             alarm_bit_o,
   output logic             irq_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (PORT_NUM < 0 || PORT_NUM > 3)
   begin : g_bad_port
      $error("PORT_NUM must be 0 to 3");
   end
   if (REPEAT_COUNT < 1 || REPEAT_COUNT > 15)
   begin : g_bad_repeat
      $error("REPEAT_COUNT must be 1 to 15");
   end

   localparam logic [3:0]  LAST_REP = 4'(REPEAT_COUNT - 1);
   localparam logic [13:0] PORT_OFS = 14'(PORT_NUM) * IDX_PORT_STRIDE;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction : merge16

   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   logic [15:0]    ctrl_ff;
   logic [15:0]    codes_ff;
   logic [15:0]    irq_en_ff;
   logic           ack_ff;
   logic [31:0]    dat_ff;
   logic           load_prev_ff;
   logic [1:0]     work_mode_ff;
   logic [5:0]     work_a_ff;
   logic [5:0]     work_b_ff;
   logic [3:0]     rep_ff;
   sender_state_t  state_ff;
   logic           alarm_bit_ff;
   logic           irq_ff;
   logic           idle_latched;

   alarm_shift_if sh ();

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Unmapped addresses, including the unused slots, still ack and read zero
   wire        req         = wb_cyc_i & wb_stb_i;
   wire        wr_fire     = req & wb_we_i & ack_ff;
   wire        rd_fire     = req & ~wb_we_i & ack_ff;
   wire [13:0] idx         = wb_adr_i[15:2];
   wire        hit_ctrl    = (idx == PORT_OFS + IDX_TX_CONTROL);
   wire        hit_codes   = (idx == PORT_OFS + IDX_TX_CODES);
   wire        hit_status  = (idx == PORT_OFS + IDX_TX_STATUS);
   wire        hit_latched = (idx == PORT_OFS + IDX_TX_STATUS_LATCHED);
   wire        hit_irq_en  = (idx == PORT_OFS + IDX_TX_IRQ_ENABLE);
   wire        sender_idle_status = (state_ff == ST_IDLE);
   wire [15:0] rd_word =
      hit_ctrl    ? ctrl_ff :
      hit_codes   ? codes_ff :
      hit_status  ? {15'h0000, sender_idle_status} :
      hit_latched ? {15'h0000, idle_latched} :
      hit_irq_en  ? irq_en_ff : 16'h0000;
   wire        latched_clr = rd_fire & hit_latched;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= req & ~ack_ff;
         dat_ff <= (req & ~ack_ff) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

   // Writes land on the edge that completes the cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff   <= RST_TX_CONTROL;
         codes_ff  <= RST_TX_CODES;
         irq_en_ff <= RST_TX_IRQ_ENABLE;
      end
      else if (wr_fire)
      begin
         if (hit_ctrl)
            ctrl_ff <= merge16(ctrl_ff, wb_dat_i, wb_sel_i);
         if (hit_codes)
            codes_ff <= merge16(codes_ff, wb_dat_i, wb_sel_i) & MASK_TX_CODES;
         if (hit_irq_en)
            irq_en_ff <= merge16(irq_en_ff, wb_dat_i, wb_sel_i) & MASK_TX_IRQ_ENABLE;
      end
   end

   // ------------------------------------------------------------
   // Load capture and sequencing
   // ------------------------------------------------------------
   // The edge relies on software dropping the bit between loads
   wire load_rise   = ctrl_ff[CTRL_LOAD_BIT] & ~load_prev_ff;
   wire [1:0] new_mode  = ctrl_ff[CTRL_MODE_LSB +: 2];
   wire last_rep    = (rep_ff == LAST_REP);
   wire word_done   = sh.done & ~load_rise;
   wire a_finished  = (state_ff == ST_SEND_A) & word_done & last_rep;
   wire b_finished  = (state_ff == ST_SEND_B) & word_done & last_rep;
   wire goto_b      = a_finished & (work_mode_ff == MODE_DUAL);
   wire next_a      = word_done & (((state_ff == ST_SEND_A) & ~last_rep) | (state_ff == ST_CONT));
   wire next_b      = word_done & (state_ff == ST_SEND_B) & ~last_rep;
   wire start_a     = load_rise & (new_mode != MODE_IDLE);

   sender_state_t nxt_state;
   always_comb
   begin
      nxt_state = state_ff;
      if (load_rise)
      begin
         case (new_mode)
            MODE_IDLE:   nxt_state = ST_IDLE;
            MODE_SINGLE: nxt_state = ST_SEND_A;
            MODE_DUAL:   nxt_state = ST_SEND_A;
            MODE_CONT:   nxt_state = ST_CONT;
            default:     nxt_state = ST_IDLE;
         endcase
      end
      else
      begin
         case (state_ff)
            ST_IDLE:   nxt_state = ST_IDLE;
            ST_SEND_A: nxt_state = goto_b ? ST_SEND_B :
                                   a_finished ? ST_IDLE : ST_SEND_A;
            ST_SEND_B: nxt_state = b_finished ? ST_IDLE : ST_SEND_B;
            ST_CONT:   nxt_state = ST_CONT;
            default:   nxt_state = ST_IDLE;
         endcase
      end
   end

   // Serializer reload: fresh start on a non-idle load, next word on each finish but the last
   assign sh.load = start_a | next_a | next_b | goto_b;
   assign sh.word = (next_b | goto_b) ? build_codeword(work_b_ff) :
                    start_a ? build_codeword(codes_ff[CODE_A_LSB +: CODE_WIDTH]) :
                    build_codeword(work_a_ff);
   assign sh.slot = overhead_slot_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         load_prev_ff <= 1'b0;
         work_mode_ff <= MODE_IDLE;
         work_a_ff    <= 6'h00;
         work_b_ff    <= 6'h00;
         rep_ff       <= 4'h0;
         state_ff     <= ST_IDLE;
      end
      else
      begin
         load_prev_ff <= ctrl_ff[CTRL_LOAD_BIT];
         state_ff     <= nxt_state;
         if (load_rise)
         begin
            work_mode_ff <= new_mode;
            work_a_ff    <= codes_ff[CODE_A_LSB +: CODE_WIDTH];
            work_b_ff    <= codes_ff[CODE_B_LSB +: CODE_WIDTH];
            rep_ff       <= 4'h0;
         end
         else if (word_done)
            rep_ff <= last_rep ? 4'h0 : rep_ff + 4'h1;
      end
   end

   codeword_serializer u_ser
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .sh    (sh)
   );

   // ------------------------------------------------------------
   // Status latch, interrupt and line output
   // ------------------------------------------------------------
   // Cleared by reading the latched register; a new rise still wins
   rise_latch #(.RESET_VAL(1'b1)) u_idle_latch
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (sender_idle_status),
      .clr_i   (latched_clr),
      .flag_o  (idle_latched)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         alarm_bit_ff <= 1'b1;
         irq_ff       <= 1'b0;
      end
      else
      begin
         alarm_bit_ff <= sender_idle_status | sh.cur_bit;
         irq_ff       <= idle_latched & irq_en_ff[IDLE_BIT] &
                         port_status_irq_enable_i[PORT_NUM];
      end
   end

   assign wb_ack_o    = ack_ff;
   assign wb_dat_o    = dat_ff;
   assign alarm_bit_o = alarm_bit_ff;
   assign irq_o       = irq_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_LOAD_CAPTURE: assert property (
      load_rise |=> work_mode_ff == $past(new_mode) && work_b_ff == $past(codes_ff[13:8]))
      else $error("load did not capture mode and codes");
   AST_LOAD_RESTART: assert property (
      (load_rise && new_mode != MODE_IDLE) |-> sh.load && sh.word == build_codeword(codes_ff[5:0]))
      else $error("load did not restart the serializer");
   AST_IDLE_ONES: assert property (
      (state_ff == ST_IDLE) [*2] |=> alarm_bit_o)
      else $error("idle sender drove a zero");
   AST_SINGLE_END: assert property (
      (a_finished && work_mode_ff == MODE_SINGLE && !load_rise) |=> state_ff == ST_IDLE)
      else $error("single mode did not return to idle");
   AST_DUAL_B: assert property (
      (goto_b && !load_rise) |=> state_ff == ST_SEND_B ##0 rep_ff == 4'h0)
      else $error("dual mode did not move to code B");
   AST_CONT_HOLD: assert property (
      (state_ff == ST_CONT && !load_rise) |=> state_ff == ST_CONT)
      else $error("continuous mode left without a load");
   AST_WORD_B: assert property (
      (sh.load && state_ff == ST_SEND_B && !load_rise) |-> sh.word[14:9] ==
         {work_b_ff[0], work_b_ff[1], work_b_ff[2], work_b_ff[3], work_b_ff[4], work_b_ff[5]})
      else $error("code B bit order wrong");
   AST_WORD_A_FRAME: assert property (
      (sh.load && !sh.word[15] && state_ff == ST_CONT && !load_rise) |->
         sh.word[7:0] == 8'hFF && !sh.word[8]
         && sh.word[14] == work_a_ff[0])
      else $error("code A framing wrong");
   AST_IDLE_LATCH: assert property (
      $rose(sender_idle_status) |=> idle_latched)
      else $error("latched idle flag missed a rise");
   AST_RESET_LATCHED: assert property (
      $past(rst_i) |-> idle_latched)
      else $error("latched idle flag clear after reset");
   AST_IRQ_GATE: assert property (
      irq_o |-> $past(idle_latched) && $past(irq_en_ff[0]) && $past(port_status_irq_enable_i[PORT_NUM]))
      else $error("interrupt without its three conditions");
   AST_ACK_PULSE: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for two cycles");

   COV_SINGLE_DONE: cover property (a_finished && work_mode_ff == MODE_SINGLE);
   COV_DUAL_B_DONE: cover property (b_finished);
   COV_CONT_WORD:   cover property (state_ff == ST_CONT && word_done);
   COV_IRQ:         cover property ($rose(irq_o));

endmodule : far_end_alarm_code_transmitter

`default_nettype wire

// *** rtl/rise_latch.sv ***
`timescale 1ns/1ns
`default_nettype none

module rise_latch
#(
   parameter logic RESET_VAL = 1'b1
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic level_i,
   input  wire logic clr_i,
   output logic      flag_o
);

   logic prev_ff;
   logic flag_ff;
   wire  rise = level_i & ~prev_ff;

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prev_ff <= 1'b1;
         flag_ff <= RESET_VAL;
      end
      else
      begin
         prev_ff <= level_i;
         flag_ff <= rise | (flag_ff & ~clr_i);
      end
   end

   assign flag_o = flag_ff;

endmodule : rise_latch

`default_nettype wire

// *** verification/framer_slot_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Framer side: overhead slot pacing and captured alarm bits
// ----------------------------------------------------------------
module framer_slot_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   input  wire logic        alarm_bit_i,
   output logic             slot_o,
   output logic [31:0]      hist_o,
   output logic [15:0]      nslot_o
);
   logic [1:0] ph_ff;

   // One slot every third cycle, keeps slots at least two cycles apart
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !en_i)
      begin
         ph_ff  <= 2'h0;
         slot_o <= 1'b0;
      end
      else
      begin
         ph_ff  <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
         slot_o <= (ph_ff == 2'h2);
      end
   end

   // Sample the alarm bit at each slot, newest bit at the bottom
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hist_o  <= 32'h0000_0000;
         nslot_o <= 16'h0000;
      end
      else if (slot_o)
      begin
         hist_o  <= {hist_o[30:0], alarm_bit_i};
         nslot_o <= nslot_o + 16'h0001;
      end
   end
endmodule : framer_slot_model

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb;
   import alarm_tx_pkg::*;

   localparam int PN = 1;
   localparam int RC = 2;

   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic        ack;
   logic        slot;
   logic        en;
   logic        abit;
   logic        irq;
   logic [15:0] adr;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic [3:0]  sel;
   logic [3:0]  pirq;
   logic [31:0] hist;
   logic [15:0] nslot;
   logic [15:0] rd;
   int          n_mismatch;
   int          n_checks;
   int          cycles;

   far_end_alarm_code_transmitter #(.PORT_NUM(PN), .REPEAT_COUNT(RC)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
      .overhead_slot_i(slot), .port_status_irq_enable_i(pirq), .alarm_bit_o(abit),
      .irq_o(irq));

   framer_slot_model u_framer (
      .clk_i(clk_i), .rst_i(rst_i), .en_i(en), .alarm_bit_i(abit), .slot_o(slot),
      .hist_o(hist), .nslot_o(nslot));

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   // Zero, code bit 0 first through bit 5, zero, eight ones
   function automatic logic [15:0] cw(input logic [5:0] c);
      cw = {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hFF};
   endfunction : cw

   function automatic logic [13:0] px(input logic [13:0] i);
      px = i + 14'(PN) * IDX_PORT_STRIDE;
   endfunction : px

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk

   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [13:0] i, input logic [15:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {i, 2'b00};
      dat <= {16'h0000, d};
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'b1 && k < 20);
      rd = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (k >= 20)
         n_mismatch++;
   endtask : wb

   // Fields first, then raise the load bit from zero
   task automatic load(input logic [1:0] m, input logic [15:0] codes);
      wb(1'b1, px(IDX_TX_CODES), codes);
      wb(1'b1, px(IDX_TX_CONTROL), {14'h0000, m});
      wb(1'b1, px(IDX_TX_CONTROL), {13'h0000, 1'b1, m});
      repeat (3) @(posedge clk_i);
   endtask : load

   // Let the framer run exactly n slots, then stop it
   task automatic slots(input int n);
      logic [15:0] tgt;
      int          k;
      tgt = nslot + 16'(n);
      en <= 1'b1;
      k = 0;
      while (nslot !== tgt && k < 3000)
      begin
         @(posedge clk_i);
         k++;
      end
      en <= 1'b0;
      if (k >= 3000)
         n_mismatch++;
   endtask : slots

   task automatic rdchk(input string nm, input logic [13:0] i, input logic [15:0] e);
      wb(1'b0, i, 16'h0000);
      chk(nm, e, rd);
   endtask : rdchk

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      rdchk("control", px(IDX_TX_CONTROL), RST_TX_CONTROL);
      rdchk("codes", px(IDX_TX_CODES), RST_TX_CODES);
      rdchk("irq_en", px(IDX_TX_IRQ_ENABLE), RST_TX_IRQ_ENABLE);
      rdchk("status", px(IDX_TX_STATUS), 16'h0001);
      rdchk("latched", px(IDX_TX_STATUS_LATCHED), 16'h0001);
      rdchk("latched2", px(IDX_TX_STATUS_LATCHED), 16'h0000);
      wb(1'b1, px(IDX_TX_CODES), 16'hFFFF);
      rdchk("codes_mask", px(IDX_TX_CODES), 16'h3F3F);
      wb(1'b1, px(IDX_TX_IRQ_ENABLE), 16'hFFFF);
      rdchk("irq_en_mask", px(IDX_TX_IRQ_ENABLE), 16'h0001);
      wb(1'b1, px(IDX_TX_IRQ_ENABLE), 16'h0000);
      rdchk("unused", px(14'h00CA), 16'h0000);
      wb(1'b1, IDX_TX_CODES, 16'h1234);
      rdchk("other_port", IDX_TX_CODES, 16'h0000);
      rdchk("codes_kept", px(IDX_TX_CODES), 16'h3F3F);
      chk("idle_bit", 16'h0001, {15'h0000, abit});
      $display("test regs done");
   endtask : t_regs

   task automatic t_single;
      pirq <= 4'h2;
      wb(1'b1, px(IDX_TX_IRQ_ENABLE), 16'h0001);
      load(2'h1, 16'h1501);
      chk("first_bit", 16'h0000, {15'h0000, abit});
      rdchk("busy", px(IDX_TX_STATUS), 16'h0000);
      rdchk("clear", px(IDX_TX_STATUS_LATCHED), 16'h0000);
      chk("irq_busy", 16'h0000, {15'h0000, irq});
      slots(16);
      chk("word_a", cw(6'h01), hist[15:0]);
      slots(16 * (RC - 1));
      repeat (3) @(posedge clk_i);
      rdchk("done", px(IDX_TX_STATUS), 16'h0001);
      chk("irq_on", 16'h0001, {15'h0000, irq});
      slots(16);
      chk("ones", 16'hFFFF, hist[15:0]);
      pirq <= 4'hD;
      repeat (3) @(posedge clk_i);
      chk("irq_port", 16'h0000, {15'h0000, irq});
      pirq <= 4'h2;
      wb(1'b1, px(IDX_TX_IRQ_ENABLE), 16'h0000);
      repeat (3) @(posedge clk_i);
      chk("irq_mask", 16'h0000, {15'h0000, irq});
      rdchk("latched", px(IDX_TX_STATUS_LATCHED), 16'h0001);
      wb(1'b1, px(IDX_TX_IRQ_ENABLE), 16'h0001);
      repeat (3) @(posedge clk_i);
      chk("irq_clr", 16'h0000, {15'h0000, irq});
      $display("test single done");
   endtask : t_single

   task automatic t_dual;
      load(2'h2, 16'h152A);
      slots(16 * RC);
      chk("dual_a", cw(6'h2A), hist[15:0]);
      slots(16 * RC);
      chk("dual_b", cw(6'h15), hist[15:0]);
      repeat (3) @(posedge clk_i);
      rdchk("dual_done", px(IDX_TX_STATUS), 16'h0001);
      $display("test dual done");
   endtask : t_dual

   task automatic t_cont_abort;
      load(2'h3, 16'h002A);
      slots(16 * (RC + 1));
      chk("cont_a", cw(6'h2A), hist[15:0]);
      rdchk("cont_busy", px(IDX_TX_STATUS), 16'h0000);
      slots(5);
      load(2'h1, 16'h0001);
      chk("restart", 16'h0000, {15'h0000, abit});
      slots(16);
      chk("new_word", cw(6'h01), hist[15:0]);
      load(2'h3, 16'h002A);
      slots(3);
      rdchk("pre_clr", px(IDX_TX_STATUS_LATCHED), 16'h0001);
      load(2'h0, 16'h002A);
      chk("halt_bit", 16'h0001, {15'h0000, abit});
      rdchk("halt_idle", px(IDX_TX_STATUS), 16'h0001);
      rdchk("halt_lat", px(IDX_TX_STATUS_LATCHED), 16'h0001);
      slots(16);
      chk("idle_ones", 16'hFFFF, hist[15:0]);
      $display("test cont_abort done");
   endtask : t_cont_abort

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 16'h0000;
      dat = 32'h0000_0000;
      sel = 4'h3;
      pirq = 4'h0;
      en = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      cycles = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_single();
      t_dual();
      t_cont_abort();
      end_sim();
   end
endmodule : tb

`default_nettype wire
